// >>> rtl/tpsr_pkg.sv
// Purpose: Constants for the tile processor status register bank.
// Assumes: Registers are numbered words reached by status read/write instructions.
// Notes:   Field positions, reset values and timing counts live here only.
package tpsr_pkg;
	// Register numbers
	localparam logic [7:0] TPSR_REG_TILE_CTRL   = 8'h02;
	localparam logic [7:0] TPSR_REG_BOOT_STAT   = 8'h03;
	localparam logic [7:0] TPSR_REG_SECURITY    = 8'h05;
	localparam logic [7:0] TPSR_REG_ROSC_CTRL   = 8'h06;
	localparam logic [7:0] TPSR_REG_ROSC_FIRST  = 8'h07;
	localparam logic [7:0] TPSR_REG_ROSC_LAST   = 8'h0a;
	localparam logic [7:0] TPSR_REG_MEM_SIZE    = 8'h0c;
	localparam logic [7:0] TPSR_REG_DBG_STATUS  = 8'h10;
	// Resource identifier form used by software
	localparam int         TPSR_RES_SHIFT       = 8;
	localparam logic [7:0] TPSR_RES_TYPE        = 8'h0b;
	// Tile control fields
	localparam int TPSR_TC_DLY_LSB   = 18;
	localparam int TPSR_TC_DLY_MSB   = 25;
	localparam int TPSR_TC_DIV_LSB   = 9;
	localparam int TPSR_TC_DIV_MSB   = 17;
	localparam int TPSR_TC_RGMII_EN  = 8;
	localparam int TPSR_TC_DYN_MODE  = 5;
	localparam int TPSR_TC_LP_EN     = 4;
	localparam int TPSR_TC_UTMI_SEL  = 2;
	localparam int TPSR_TC_ULPI_EN   = 1;
	localparam logic [31:0] TPSR_TC_WMASK = 32'h03ff_ff36;
	localparam logic [31:0] TPSR_TC_RESET = 32'h0000_0000;
	// Boot status fields
	localparam logic [31:0] TPSR_BOOT_MASK = 32'h00ff_013f;
	// Security fields
	localparam int TPSR_SEC_LOCK     = 31;
	localparam int TPSR_SEC_DBG_OFF  = 14;
	localparam int TPSR_SEC_OTP_ALL  = 12;
	localparam int TPSR_SEC_OTP_LSB  = 8;
	localparam int TPSR_SEC_OTP_MSB  = 11;
	localparam int TPSR_SEC_OTP_RED  = 7;
	localparam int TPSR_SEC_OTP_BOOT = 5;
	localparam int TPSR_SEC_JTAG_CFG = 4;
	localparam int TPSR_SEC_JTAG_TAP = 0;
	localparam logic [31:0] TPSR_SEC_MASK  = 32'h8000_5fb1;
	localparam logic [31:0] TPSR_SEC_RESET = 32'h0000_0000;
	// Ring oscillator control
	localparam int TPSR_RO_CORE_EN   = 1;
	localparam int TPSR_RO_PERI_EN   = 0;
	localparam logic [1:0] TPSR_RO_RESET = 2'h0;
	localparam int TPSR_RO_STOP_CYC  = 10;
	// Memory size field
	localparam logic [31:0] TPSR_MEM_MASK  = 32'hffff_fffc;
	// Saved status word fields
	localparam logic [31:0] TPSR_SSW_MASK  = 32'h0000_07df;
	localparam int TPSR_SSW_ISSUE    = 8;
	localparam logic [31:0] TPSR_SSW_RESET = 32'h0000_0000;
	// Divider counter resets
	localparam logic [8:0] TPSR_DIV_RESET  = 9'h000;
	localparam logic [7:0] TPSR_DLY_RESET  = 8'h00;
endpackage : tpsr_pkg

// >>> rtl/tpsr_regs.sv
// Purpose: Processor status register bank of a tile: control, boot, security,
//          ring oscillator counters, memory size and debug saved status.
// Assumes: Status accesses are single-cycle word requests from the core; pll side
//          logic runs on clk as well, advanced by pll_tick.
// Notes:   Ring counters are fed by oscillator toggles synchronised into clk.
// Behaviour
// - Delay transmit data by control bits 25:18
// - Transmit clock high at divider, low at half
// - RGMII ports connected only while bit 8
// - Bit 4 enables low-power clock divider
// - Bit 5 divides only when threads paused
// - Bit 2 selects UTMI, else ULPI
// - Bit 1 enables ULPI support module
// - Boot status read-only with listed fields
// - Security bit 31 blocks further writes
// - Lock OTP sectors per bits 11:8, 12
// - Bits 4,0,14 block JTAG config, TAP, debug
// - Bit 5 boots from OTP; bit 7 redundancy
// - Security register loaded from OTP word
// - Four oscillators; control bits start/stop them
// - Counts in 15:0 at registers 0x07-0x0A
// - Counts survive system reset
// - Oscillators asynchronous to tile clock
// - Memory size read-only in bits 31:2
// - Debug entry copies saved status word
// - Status bit 7 fast, bit 6 paused
// - Status bits 4..0 kernel, irq, events
// - Status bits 10, 9, read-only 8
// - Word reads and writes by status instructions
`timescale 1ns/100ps
module tpsr_regs
	import tpsr_pkg::*;
(
	input  wire logic        clk,            // Tile core clock
	input  wire logic        rst,            // Asynchronous reset, active high
	input  wire logic        ce,             // Clock enable, freezes all state
	input  wire logic        ps_wr,          // Status write strobe
	input  wire logic        ps_rd,          // Status read strobe
	input  wire logic [7:0]  ps_num,         // Register number
	input  wire logic [31:0] ps_wdata,       // Write data
	input  wire logic        debug_only_read_write, // Debug mode write permission
	input  wire logic        dbg_entry,      // Debugger entry pulse
	input  wire logic [31:0] saved_status_word, // Thread status at entry
	input  wire logic [31:0] boot_status_in, // Boot straps and processor number
	input  wire logic        otp_valid,      // Security word from OTP is valid
	input  wire logic [31:0] otp_security,   // Security word read from OTP
	input  wire logic [31:0] mem_size_bytes, // Memory size in bytes
	input  wire logic        pll_tick,       // One pulse per PLL output cycle
	input  wire logic        threads_paused, // All active threads paused
	input  wire logic [3:0]  rosc_toggle,    // Raw oscillator toggles, asynchronous
	input  wire logic        rgmii_txd_in,   // Transmit data before delay
	output logic [31:0]      ps_rdata,       // Read data
	output logic             ps_ack,         // Access done, one cycle
	output logic             rgmii_txd,      // Delayed transmit data
	output logic             rgmii_txc,      // Transmit clock
	output logic             rgmii_port_en,  // RGMII connected to ports
	output logic             lp_clk_div_en,  // Low power division applied
	output logic             utmi_sel,       // 1 UTMI, 0 ULPI
	output logic             ulpi_en,        // ULPI support enabled
	output logic [3:0]       otp_sector_lock,// Per-sector OTP lock
	output logic             jtag_cfg_block, // JTAG to PLL/boot regs blocked
	output logic             jtag_tap_block, // JTAG debug TAP blocked
	output logic             global_dbg_block, // Global debug blocked
	output logic             otp_boot,       // Boot image from OTP
	output logic             otp_redundancy, // OTP redundancy enabled
	output logic [1:0]       rosc_run        // Core, peripheral oscillator enables
);

	// All state of the bank except the oscillator counts
	typedef struct packed {
		logic [31:0] tile_ctrl;   // Tile control
		logic [31:0] security;    // Security configuration
		logic [1:0]  rosc_ctrl;   // Oscillator enables
		logic [31:0] dbg_status;  // Captured saved status word
		logic [31:0] rdata;       // Read data register
		logic        ack;         // Access done
		logic [8:0]  div_cnt;     // Transmit clock counter
		logic        txc;         // Transmit clock
		logic [255:0] dly_line;   // Transmit data delay line
		logic        txd;         // Delayed data
		logic [3:0]  sync1;       // Oscillator sync stage one
		logic [3:0]  sync2;       // Oscillator sync stage two
		logic [3:0]  sync3;       // Edge history
		logic        lp_en;       // Low power division applied
		logic [3:0]  sec_lock;    // Registered per-sector OTP lock
	} tpsr_state_t;

	tpsr_state_t s_q;              // Registered state
	tpsr_state_t s_d;              // Next state
	// Counts power up at zero and are never reset, so a system reset cannot clear them
	logic [15:0] rosc_cnt_q [4] = '{default: 16'h0000};
	logic [3:0]  rosc_edge;        // Counted oscillator edges
	logic [7:0]  dly_sel;          // Delay field
	logic [8:0]  div_val;          // Divider field

	assign dly_sel = s_q.tile_ctrl[TPSR_TC_DLY_MSB:TPSR_TC_DLY_LSB];
	assign div_val = s_q.tile_ctrl[TPSR_TC_DIV_MSB:TPSR_TC_DIV_LSB];
	assign rosc_edge = s_q.sync2 ^ s_q.sync3;

	// Next state of the bank
	always_comb begin
		s_d = s_q;
		s_d.ack = 1'b0;
		// Word reads, reserved bits masked to zero
		if (ps_rd) begin
			s_d.ack = 1'b1;
			if (ps_num == TPSR_REG_TILE_CTRL) begin
				s_d.rdata = s_q.tile_ctrl & TPSR_TC_WMASK;
			end else if (ps_num == TPSR_REG_BOOT_STAT) begin
				s_d.rdata = boot_status_in & TPSR_BOOT_MASK;
			end else if (ps_num == TPSR_REG_SECURITY) begin
				s_d.rdata = s_q.security & TPSR_SEC_MASK;
			end else if (ps_num == TPSR_REG_ROSC_CTRL) begin
				s_d.rdata = {30'h0, s_q.rosc_ctrl};
			end else if (ps_num >= TPSR_REG_ROSC_FIRST && ps_num <= TPSR_REG_ROSC_LAST) begin
				s_d.rdata = {16'h0, rosc_cnt_q[2'(ps_num - TPSR_REG_ROSC_FIRST)]};
			end else if (ps_num == TPSR_REG_MEM_SIZE) begin
				s_d.rdata = mem_size_bytes & TPSR_MEM_MASK;
			end else if (ps_num == TPSR_REG_DBG_STATUS) begin
				s_d.rdata = s_q.dbg_status & TPSR_SSW_MASK;
			end else begin
				s_d.rdata = 32'h0000_0000; // Unmapped reads zero
			end
		end
		// Word writes; read-only registers ignore them
		if (ps_wr) begin
			s_d.ack = 1'b1;
			if (ps_num == TPSR_REG_TILE_CTRL) begin
				s_d.tile_ctrl = ps_wdata & TPSR_TC_WMASK;
			end else if (ps_num == TPSR_REG_SECURITY) begin
				if (!s_q.security[TPSR_SEC_LOCK]) begin
					s_d.security = ps_wdata & TPSR_SEC_MASK;
				end
			end else if (ps_num == TPSR_REG_ROSC_CTRL) begin
				s_d.rosc_ctrl = ps_wdata[1:0];
			end else if (ps_num == TPSR_REG_DBG_STATUS && debug_only_read_write) begin
				// Issue mode bit 8 stays read-only
				s_d.dbg_status = (ps_wdata & TPSR_SSW_MASK & ~(32'h1 << TPSR_SSW_ISSUE))
					| (s_q.dbg_status & (32'h1 << TPSR_SSW_ISSUE));
			end
		end
		// Debug entry capture wins over a software write in the same cycle
		if (dbg_entry) begin
			s_d.dbg_status = saved_status_word & TPSR_SSW_MASK;
		end
		// OTP load of the security word; a later load is refused once locked
		if (otp_valid && !s_q.security[TPSR_SEC_LOCK]) begin
			s_d.security = otp_security & TPSR_SEC_MASK;
		end
		// Sector locks taken from the next security word so the pins leave a flip-flop
		s_d.sec_lock = s_d.security[TPSR_SEC_OTP_MSB:TPSR_SEC_OTP_LSB]
			| {4{s_d.security[TPSR_SEC_OTP_ALL]}};
		// PLL-rate logic: transmit clock and delay line
		if (pll_tick) begin
			if (s_q.div_cnt >= div_val) begin
				s_d.div_cnt = TPSR_DIV_RESET;
			end else begin
				s_d.div_cnt = s_q.div_cnt + 9'h001;
			end
			if (s_q.div_cnt == div_val) begin
				s_d.txc = 1'b1;
			end else if (s_q.div_cnt == (div_val >> 1)) begin
				s_d.txc = 1'b0;
			end
			s_d.dly_line = {s_q.dly_line[254:0], rgmii_txd_in};
			s_d.txd = (dly_sel == TPSR_DLY_RESET) ? rgmii_txd_in : s_q.dly_line[dly_sel - 8'h01];
		end
		// Low power division, dynamic mode waits for all threads paused
		s_d.lp_en = s_q.tile_ctrl[TPSR_TC_LP_EN]
			&& (!s_q.tile_ctrl[TPSR_TC_DYN_MODE] || threads_paused);
		// Oscillator toggles into clk domain
		s_d.sync1 = rosc_toggle;
		s_d.sync2 = s_q.sync1;
		s_d.sync3 = s_q.sync2;
	end

	// Register the state
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			s_q <= '0;
			s_q.tile_ctrl <= TPSR_TC_RESET;
			s_q.security <= TPSR_SEC_RESET;
			s_q.rosc_ctrl <= TPSR_RO_RESET;
			s_q.dbg_status <= TPSR_SSW_RESET;
		end else if (ce) begin
			s_q <= s_d;
		end
	end

	// Counters have no reset so counts survive a system reset
	genvar gi;
	generate
		for (gi = 0; gi < 4; gi++) begin : g_rosc
			always_ff @(posedge clk) begin
				if (ce && rosc_edge[gi] && s_q.rosc_ctrl[gi < 2 ? TPSR_RO_CORE_EN : TPSR_RO_PERI_EN]) begin
					rosc_cnt_q[gi] <= rosc_cnt_q[gi] + 16'h0001;
				end
			end
		end
	endgenerate

	// Outputs straight from flip-flops
	assign ps_rdata         = s_q.rdata;
	assign ps_ack           = s_q.ack;
	assign rgmii_txd        = s_q.txd;
	assign rgmii_txc        = s_q.txc;
	assign rgmii_port_en    = s_q.tile_ctrl[TPSR_TC_RGMII_EN];
	assign lp_clk_div_en    = s_q.lp_en;
	assign utmi_sel         = s_q.tile_ctrl[TPSR_TC_UTMI_SEL];
	assign ulpi_en          = s_q.tile_ctrl[TPSR_TC_ULPI_EN];
	assign otp_sector_lock  = s_q.sec_lock;
	assign jtag_cfg_block   = s_q.security[TPSR_SEC_JTAG_CFG];
	assign jtag_tap_block   = s_q.security[TPSR_SEC_JTAG_TAP];
	assign global_dbg_block = s_q.security[TPSR_SEC_DBG_OFF];
	assign otp_boot         = s_q.security[TPSR_SEC_OTP_BOOT];
	assign otp_redundancy   = s_q.security[TPSR_SEC_OTP_RED];
	assign rosc_run         = s_q.rosc_ctrl;

	// Assertions
	a_sec_lock_hold: assert property (@(posedge clk) disable iff (rst)
		ce && s_q.security[TPSR_SEC_LOCK] && !otp_valid |=> s_q.security == $past(s_q.security))
		else $error("security changed while locked");
	a_ack_follows: assert property (@(posedge clk) disable iff (rst)
		ce && (ps_rd || ps_wr) |=> ps_ack)
		else $error("access not acknowledged");
	a_dbg_capture: assert property (@(posedge clk) disable iff (rst)
		ce && dbg_entry |=> s_q.dbg_status == ($past(saved_status_word) & TPSR_SSW_MASK))
		else $error("saved status not captured");
	a_ctrl_reserved: assert property (@(posedge clk) disable iff (rst)
		(s_q.tile_ctrl & ~TPSR_TC_WMASK) == 32'h0)
		else $error("reserved control bit set");
	a_lp_static: assert property (@(posedge clk) disable iff (rst)
		ce && s_q.tile_ctrl[TPSR_TC_LP_EN] && !s_q.tile_ctrl[TPSR_TC_DYN_MODE] |=> lp_clk_div_en)
		else $error("static division not applied");
	a_lp_dynamic: assert property (@(posedge clk) disable iff (rst)
		ce && s_q.tile_ctrl[TPSR_TC_DYN_MODE] && !threads_paused |=> !lp_clk_div_en)
		else $error("dynamic division applied while running");
	a_otp_lock_all: assert property (@(posedge clk) disable iff (rst)
		s_q.security[TPSR_SEC_OTP_ALL] |-> otp_sector_lock == 4'hf)
		else $error("sector unlocked under lock all");
	a_txc_high: assert property (@(posedge clk) disable iff (rst)
		ce && pll_tick && s_q.div_cnt == div_val |=> rgmii_txc)
		else $error("transmit clock not high at divider");
	a_boot_ro: assert property (@(posedge clk) disable iff (rst)
		ce && ps_rd && ps_num == TPSR_REG_BOOT_STAT |=> ps_rdata == ($past(boot_status_in) & TPSR_BOOT_MASK))
		else $error("boot status mismatch");

endmodule : tpsr_regs

// >>> sim/tpsr_regs_tb.sv
// Purpose: Self-checking bench for the tile processor status register bank.
// Assumes: Every status access is acked one cycle after it is taken.
// Notes:   Oscillator counts power up at zero, so each count is compared exactly, as is the last count's retention over reset.
`timescale 1ns/100ps
module tpsr_regs_tb;
	import tpsr_pkg::*;
	logic        clk, rst, ce, ps_wr, ps_rd, debug_only_read_write, dbg_entry, otp_valid;
	logic        pll_tick, threads_paused, rgmii_txd_in, ps_ack, rgmii_txd, rgmii_txc;
	logic        rgmii_port_en, lp_clk_div_en, utmi_sel, ulpi_en, otp_boot, otp_redundancy;
	logic        jtag_cfg_block, jtag_tap_block, global_dbg_block, prev;
	logic [7:0]  ps_num;
	logic [31:0] ps_wdata, saved_status_word, boot_status_in, otp_security, mem_size_bytes, ps_rdata;
	logic [3:0]  rosc_toggle, otp_sector_lock;
	logic [1:0]  rosc_run;
	logic [31:0] seed, tc, sec, ssw, rd, w, c0;   // Bench model words
	int          miscompares, compares, cycles, n, rises, l2, l6;
	logic [7:0]  zr [6] = '{8'h02, 8'h05, 8'h06, 8'h10, 8'h04, 8'h0b};   // Zero after reset

	tpsr_regs i_dut (.clk(clk), .rst(rst), .ce(ce), .ps_wr(ps_wr), .ps_rd(ps_rd), .ps_num(ps_num),
		.ps_wdata(ps_wdata), .debug_only_read_write(debug_only_read_write), .dbg_entry(dbg_entry),
		.saved_status_word(saved_status_word), .boot_status_in(boot_status_in), .otp_valid(otp_valid),
		.otp_security(otp_security), .mem_size_bytes(mem_size_bytes), .pll_tick(pll_tick),
		.threads_paused(threads_paused), .rosc_toggle(rosc_toggle), .rgmii_txd_in(rgmii_txd_in),
		.ps_rdata(ps_rdata), .ps_ack(ps_ack), .rgmii_txd(rgmii_txd), .rgmii_txc(rgmii_txc),
		.rgmii_port_en(rgmii_port_en), .lp_clk_div_en(lp_clk_div_en), .utmi_sel(utmi_sel),
		.ulpi_en(ulpi_en), .otp_sector_lock(otp_sector_lock), .jtag_cfg_block(jtag_cfg_block),
		.jtag_tap_block(jtag_tap_block), .global_dbg_block(global_dbg_block), .otp_boot(otp_boot),
		.otp_redundancy(otp_redundancy), .rosc_run(rosc_run));

	// Free-running 100 MHz clock
	always #5 clk = ~clk;

	// Hang guard: ceiling far above the few hundred cycles the sequence needs
	always @(posedge clk) begin
		cycles++;
		if (cycles == 20000) begin
			miscompares++;
			give_verdict();
		end
	end

	// Xorshift source, fixed start so runs repeat
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction : rnd

	task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			miscompares++;
			$display("FAIL %s expected %h seen %h", name, exp, seen);
		end
	endtask : check

	// One status access; strobes drop after the edge that takes them
	task automatic acc(input logic wr, input logic [7:0] num, input logic [31:0] data);
		@(posedge clk);
		ps_wr    <= wr;
		ps_rd    <= ~wr;
		ps_num   <= num;
		ps_wdata <= data;
		@(posedge clk);
		ps_wr <= 1'b0;
		ps_rd <= 1'b0;
		#1;
		check("ps_ack", {31'h0, ps_ack}, 32'h1);
		rd = ps_rdata;
	endtask : acc

	task automatic rchk(input logic [7:0] num, input logic [31:0] exp);
		acc(1'b0, num, 32'h0);
		check("ps_rdata", rd, exp);
	endtask : rchk

	// Security outputs follow the model word
	task automatic sec_out();
		check("otp_lock", otp_sector_lock, sec[11:8] | {4{sec[12]}});
		check("jtag_cfg", jtag_cfg_block, sec[4]);
		check("jtag_tap", jtag_tap_block, sec[0]);
		check("glob_dbg", global_dbg_block, sec[14]);
		check("otp_boot", {otp_redundancy, otp_boot}, {sec[7], sec[5]});
	endtask : sec_out

	task automatic otp_load(input logic [31:0] v);
		otp_security <= v;
		otp_valid    <= 1'b1;
		@(posedge clk);
		otp_valid <= 1'b0;
	endtask : otp_load

	// Cycles from a rising data edge to the delayed output, pll ticking every cycle
	task automatic dly_lat(input logic [7:0] d, output int lat);
		acc(1'b1, TPSR_REG_TILE_CTRL, {6'h0, d, 18'h0});
		rgmii_txd_in <= 1'b0;
		repeat (20) @(posedge clk);
		rgmii_txd_in <= 1'b1;
		lat = 0;
		while (rgmii_txd !== 1'b1 && lat < 60) begin
			@(posedge clk);
			#1;
			lat++;
		end
	endtask : dly_lat

	task automatic give_verdict();
		if (miscompares == 0 && compares > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : give_verdict

	initial begin
		{clk, ps_wr, ps_rd, debug_only_read_write, dbg_entry, otp_valid, threads_paused} = '0;
		{rgmii_txd_in, ps_num, ps_wdata, saved_status_word, otp_security, rosc_toggle} = '0;
		{boot_status_in, mem_size_bytes, miscompares, compares, cycles} = '0;
		rst      = 1'b1;
		ce       = 1'b1;
		pll_tick = 1'b1;
		seed     = 32'd91512;
		repeat (3) @(posedge clk);
		rst <= 1'b0;
		// Reset values, unmapped reads
		foreach (zr[i]) rchk(zr[i], 32'h0);
		// Control fields and the pins they drive
		repeat (4) begin
			w = rnd();
			acc(1'b1, TPSR_REG_TILE_CTRL, w);
			tc = w & TPSR_TC_WMASK;
			rchk(TPSR_REG_TILE_CTRL, tc);
			check("port_en", rgmii_port_en, tc[8]);
			check("utmi_ulpi", {utmi_sel, ulpi_en}, tc[2:1]);
		end
		// Every combination of enable, mode and pause
		for (n = 0; n < 8; n++) begin
			threads_paused <= n[2];
			acc(1'b1, TPSR_REG_TILE_CTRL, {26'h0, n[1], n[0], 4'h0});
			@(posedge clk);
			#1;
			check("lp_div", lp_clk_div_en, n[0] & (~n[1] | n[2]));
		end
		// Divide ratio four: one rising clock per four ticks
		acc(1'b1, TPSR_REG_TILE_CTRL, 32'h0000_0600);
		rises = 0;
		prev  = rgmii_txc;
		repeat (80) begin
			@(posedge clk);
			#1;
			if (rgmii_txc === 1'b1 && prev === 1'b0)
				rises++;
			prev = rgmii_txc;
		end
		check("txc_rises", (rises >= 19 && rises <= 21), 32'h1);
		dly_lat(8'h02, l2);
		dly_lat(8'h06, l6);
		check("txd_delay", l6 - l2, 32'h4);
		// Read-only status words ignore writes
		boot_status_in <= rnd();
		mem_size_bytes <= rnd();
		acc(1'b1, TPSR_REG_BOOT_STAT, 32'hffff_ffff);
		acc(1'b1, TPSR_REG_MEM_SIZE, 32'h0);
		acc(1'b1, 8'h04, 32'hffff_ffff);
		rchk(8'h04, 32'h0);
		rchk(TPSR_REG_BOOT_STAT, boot_status_in & TPSR_BOOT_MASK);
		rchk(TPSR_REG_MEM_SIZE, mem_size_bytes & TPSR_MEM_MASK);
		// OTP load, then a software write that sets the lock; later writes and loads are refused
		w = rnd() & 32'h7fff_ffff;
		otp_load(w);
		sec = w & TPSR_SEC_MASK;
		rchk(TPSR_REG_SECURITY, sec);
		sec_out();
		w = rnd() | 32'h8000_0000;
		acc(1'b1, TPSR_REG_SECURITY, w);
		sec = w & TPSR_SEC_MASK;
		acc(1'b1, TPSR_REG_SECURITY, ~w);
		otp_load(~w);
		rchk(TPSR_REG_SECURITY, sec);
		sec_out();
		// Oscillators run, stop, settle twelve cycles, then read
		acc(1'b1, TPSR_REG_ROSC_CTRL, 32'hffff_ffff);
		rchk(TPSR_REG_ROSC_CTRL, 32'h3);
		check("rosc_run", rosc_run, 32'h3);
		repeat (40) @(posedge clk) rosc_toggle <= ~rosc_toggle;
		acc(1'b1, TPSR_REG_ROSC_CTRL, 32'h0);
		repeat (12) @(posedge clk);
		for (n = 0; n < 4; n++) begin
			acc(1'b0, TPSR_REG_ROSC_FIRST + n[7:0], 32'h0);
			check("rosc_hi", rd[31:16], 32'h0);
			check("rosc_cnt", rd, 32'h0000_0027);
		end
		c0 = rd;
		// Mid-run reset keeps the count but clears control
		rst <= 1'b1;
		repeat (3) @(posedge clk);
		rst <= 1'b0;
		rchk(TPSR_REG_ROSC_LAST, c0);
		rchk(TPSR_REG_TILE_CTRL, 32'h0);
		// Debugger entry capture, guarded writes, read-only issue bit
		w = rnd();
		saved_status_word <= w;
		dbg_entry         <= 1'b1;
		@(posedge clk);
		dbg_entry <= 1'b0;
		ssw = w & TPSR_SSW_MASK;
		rchk(TPSR_REG_DBG_STATUS, ssw);
		acc(1'b1, TPSR_REG_DBG_STATUS, ~w);
		rchk(TPSR_REG_DBG_STATUS, ssw);
		debug_only_read_write <= 1'b1;
		acc(1'b1, TPSR_REG_DBG_STATUS, ~w);
		ssw = (~w & TPSR_SSW_MASK & 32'hffff_feff) | (ssw & 32'h0000_0100);
		rchk(TPSR_REG_DBG_STATUS, ssw);
		give_verdict();
	end
endmodule : tpsr_regs_tb
